/* File: core/tpm_perf_monitor.sv */
// T1/J1 receive performance monitor: counters, transfers, indirect access and overflow interrupts
// Functional notes
// (RQ1) counted events follow the selected framing format
// (RQ2) overflow sets flag; enabled flag raises interrupt
// (RQ3) auto enable transfers counts every second
// (RQ4) manual trigger rising edge always transfers counts
// (RQ5) counters clear after each transfer
// (RQ6) events during transfer are never lost
// (RQ7) link and index fields pick indirect register
// (RQ8) access data shows selected indirect byte
// (RQ9) 16-bit line violation count, indices 09/08
// (RQ10) 12-bit framing error count, indices 03/02
// (RQ11) 10-bit CRC-6 count, extended superframe only
// (RQ12) 10-bit DDS count, digital multiplex only
// (RQ13) 3-bit alignment change count, index 04
// (RQ14) 5-bit sync loss count, index 05
// (RQ15) 16-bit PRBS error count, indices 07/06
// (RQ16) digital multiplex format only in T1 mode
// (RQ17) flags stay set until cleared; interrupt level
`timescale 1ns/10ps
module tpm_perf_monitor #(
	parameter int          NUM_LINKS   = 8,
	parameter int unsigned TICK_CYCLES = tpm_pkg::TICK_CYCLES_DFLT
) (
	input  wire logic                        i_clock,
	input  wire logic                        i_rstn,
	input  wire logic [tpm_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [tpm_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [tpm_pkg::DATA_W-1:0]  o_rdata,
	input  wire logic [NUM_LINKS-1:0]        i_line_violation_evt,
	input  wire logic [NUM_LINKS-1:0]        i_fbit_error_evt,
	input  wire logic [NUM_LINKS-1:0]        i_fas_error_evt,
	input  wire logic [NUM_LINKS-1:0]        i_crc6_error_evt,
	input  wire logic [NUM_LINKS-1:0]        i_dds_error_evt,
	input  wire logic [NUM_LINKS-1:0]        i_alignment_change_evt,
	input  wire logic [NUM_LINKS-1:0]        i_sync_loss_evt,
	input  wire logic [NUM_LINKS-1:0]        i_prbs_error_evt,
	output logic                             o_irq
);
	import tpm_pkg::*;

	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	// per-link register hit: the top three address bits carry the link
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [2:0] lnk, input logic [7:0] off);
		return a == {lnk, off};
	endfunction

	logic [TW-1:0]     tick_cnt_reg;
	logic [TW-1:0]     tick_cnt_next;
	logic              tick;
	logic [ACC_W-1:0]  access_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rd_next;
	logic              acc_wr;
	logic [2:0]        acc_link;
	logic [3:0]        acc_idx;
	logic [2:0]        bus_link;
	logic              acc_link_ok;
	logic              bus_link_ok;
	logic [DATA_W-1:0] link_rd  [NUM_LINKS];
	logic [DATA_W-1:0] link_ind [NUM_LINKS];
	logic [NUM_LINKS-1:0] link_irq;

	// one shared second tick keeps all links' intervals aligned
	assign tick          = (tick_cnt_reg == TICK_LAST);
	assign tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next; // RQ3
		end
	end

	// indirect addressing
	assign acc_wr      = i_wr && (i_addr == ADDR_ACCESS_PORT);
	assign acc_link    = access_reg[ACC_LINK_HI:ACC_LINK_LO]; // RQ7
	assign acc_idx     = access_reg[ACC_IDX_HI:ACC_IDX_LO]; // RQ7
	assign bus_link    = i_addr[ADDR_W-1:ADDR_W-3];
	assign acc_link_ok = int'(acc_link) < NUM_LINKS;
	assign bus_link_ok = int'(bus_link) < NUM_LINKS;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			access_reg <= RST_ACCESS;
		end else if (acc_wr) begin
			access_reg <= i_wdata[ACC_W-1:0];
		end
	end

	genvar l;
	generate
		for (l = 0; l < NUM_LINKS; l++) begin : g_link
			localparam logic [2:0] LID = 3'(l);

			logic [CTRL_W-1:0] ctrl_reg;
			logic              manual_prev_reg;
			logic [7:0]        en0_reg;
			logic [7:0]        en1_reg;
			logic [7:0]        flg0_reg;
			logic [7:0]        flg1_reg;
			logic [7:0]        flg0_next;
			logic [7:0]        flg1_next;
			logic [7:0]        ovf0;
			logic [7:0]        ovf1;
			logic [7:0]        clr0;
			logic [7:0]        clr1;
			logic [7:0]        ind_byte;
			logic [7:0]        rd_byte;
			logic [CNT_NUM-1:0] evt;
			logic [CNT_NUM-1:0] ovf;
			logic [RESULT_W-1:0] res [CNT_NUM];
			logic              wr_ctrl;
			logic              wr_en0;
			logic              wr_en1;
			logic              xfer;
			logic              manual_rise;
			logic              j1_mode;
			logic              dm_active;
			tpm_format_type    fmt;

			assign wr_ctrl = i_wr && reg_hit(i_addr, LID, OFF_CONTROL);
			assign wr_en0  = i_wr && reg_hit(i_addr, LID, OFF_IRQ_EN0);
			assign wr_en1  = i_wr && reg_hit(i_addr, LID, OFF_IRQ_EN1);
			assign clr0    = (i_wr && reg_hit(i_addr, LID, OFF_IRQ_CLR0)) ? i_wdata : 8'h00;
			assign clr1    = (i_wr && reg_hit(i_addr, LID, OFF_IRQ_CLR1)) ? i_wdata : 8'h00;

			assign fmt         = tpm_format_type'(ctrl_reg[BIT_FMT_HI:BIT_FMT_LO]);
			assign j1_mode     = ctrl_reg[BIT_J1];
			// in J1 mode the digital multiplex code is not offered
			assign dm_active   = (fmt == FMT_DM) && !j1_mode; // RQ16
			assign manual_rise = ctrl_reg[BIT_MANUAL] && !manual_prev_reg; // RQ4
			assign xfer        = (ctrl_reg[BIT_AUTO] && tick) || manual_rise; // RQ3 RQ4

			// event steering by framing format
			assign evt[CNT_LCV]  = i_line_violation_evt[l]; // RQ9
			assign evt[CNT_FER]  = (fmt == FMT_ESF) ? i_fas_error_evt[l] : i_fbit_error_evt[l]; // RQ1 RQ10
			assign evt[CNT_CRC]  = (fmt == FMT_ESF) && i_crc6_error_evt[l]; // RQ1 RQ11
			assign evt[CNT_DDS]  = dm_active && i_dds_error_evt[l]; // RQ1 RQ12 RQ16
			assign evt[CNT_ALIGNMENT_CHANGE_COUNTER] = i_alignment_change_evt[l]; // RQ13
			// sync loss of an unoffered format is not counted
			assign evt[CNT_OOF]  = i_sync_loss_evt[l] && !((fmt == FMT_DM) && j1_mode); // RQ14 RQ16
			assign evt[CNT_PRBS] = i_prbs_error_evt[l]; // RQ15

			genvar k;
			for (k = 0; k < CNT_NUM; k++) begin : g_cnt
				tpm_cnt_if c_if ();
				assign c_if.evt  = evt[k];
				assign c_if.xfer = xfer; // RQ5
				assign res[k]    = c_if.result;
				assign ovf[k]    = c_if.ovf;
				tpm_counter #(
					.W (CNT_WIDTH[k])
				) u_cnt (
					.i_clock (i_clock),
					.i_rstn  (i_rstn),
					.cnt     (c_if.cnt)
				);
			end

			always_comb begin
				ovf0            = 8'h00;
				ovf1            = 8'h00;
				ovf0[FLG0_FER]  = ovf[CNT_FER];
				ovf0[FLG0_ALIGNMENT_CHANGE_COUNTER] = ovf[CNT_ALIGNMENT_CHANGE_COUNTER];
				ovf0[FLG0_OOF]  = ovf[CNT_OOF];
				ovf0[FLG0_PRBS] = ovf[CNT_PRBS];
				ovf0[FLG0_CRC]  = ovf[CNT_CRC];
				ovf0[FLG0_DDS]  = ovf[CNT_DDS];
				ovf1[FLG1_LCV]  = ovf[CNT_LCV];
			end

			// a new overflow wins over a clear in the same cycle
			assign flg0_next = (flg0_reg & ~clr0) | ovf0; // RQ2 RQ17
			assign flg1_next = (flg1_reg & ~clr1) | ovf1; // RQ2 RQ17

			always_ff @(posedge i_clock or negedge i_rstn) begin
				if (!i_rstn) begin
					ctrl_reg        <= RST_CONTROL;
					manual_prev_reg <= 1'b0;
					en0_reg         <= RST_IRQ;
					en1_reg         <= RST_IRQ;
					flg0_reg        <= RST_IRQ;
					flg1_reg        <= RST_IRQ;
				end else begin
					manual_prev_reg <= ctrl_reg[BIT_MANUAL];
					flg0_reg        <= flg0_next;
					flg1_reg        <= flg1_next;
					if (wr_ctrl) begin
						ctrl_reg <= i_wdata[CTRL_W-1:0];
					end
					if (wr_en0) begin
						en0_reg <= i_wdata;
					end
					if (wr_en1) begin
						en1_reg <= i_wdata;
					end
				end
			end

			// indirect result bytes; unused indices read zero
			always_comb begin
				ind_byte = 8'h00;
				unique case (acc_idx)
					IDX_CRC_LO:  ind_byte = res[CNT_CRC][7:0]; // RQ11
					IDX_CRC_HI:  ind_byte = res[CNT_CRC][15:8];
					IDX_FER_LO:  ind_byte = res[CNT_FER][7:0]; // RQ10
					IDX_FER_HI:  ind_byte = res[CNT_FER][15:8];
					IDX_ALIGNMENT_CHANGE_COUNTER:    ind_byte = res[CNT_ALIGNMENT_CHANGE_COUNTER][7:0]; // RQ13
					IDX_OOF:     ind_byte = res[CNT_OOF][7:0]; // RQ14
					IDX_PRBS_LO: ind_byte = res[CNT_PRBS][7:0]; // RQ15
					IDX_PRBS_HI: ind_byte = res[CNT_PRBS][15:8];
					IDX_LCV_LO:  ind_byte = res[CNT_LCV][7:0]; // RQ9
					IDX_LCV_HI:  ind_byte = res[CNT_LCV][15:8];
					IDX_DDS_LO:  ind_byte = res[CNT_DDS][7:0]; // RQ12
					IDX_DDS_HI:  ind_byte = res[CNT_DDS][15:8];
					default:     ind_byte = 8'h00;
				endcase
			end

			// direct reads of this link; clear registers are write-only
			always_comb begin
				rd_byte = 8'h00;
				if (reg_hit(i_addr, LID, OFF_CONTROL)) begin
					rd_byte = 8'(ctrl_reg);
				end else if (reg_hit(i_addr, LID, OFF_IRQ_EN0)) begin
					rd_byte = en0_reg;
				end else if (reg_hit(i_addr, LID, OFF_IRQ_EN1)) begin
					rd_byte = en1_reg;
				end else if (reg_hit(i_addr, LID, OFF_IRQ_FLG0)) begin
					rd_byte = flg0_reg;
				end else if (reg_hit(i_addr, LID, OFF_IRQ_FLG1)) begin
					rd_byte = flg1_reg;
				end
			end

			assign link_rd[l]  = rd_byte;
			assign link_ind[l] = ind_byte;
			assign link_irq[l] = |(flg0_reg & en0_reg) || |(flg1_reg & en1_reg); // RQ2 RQ17

			sequence s_manual_rise;
				!ctrl_reg[BIT_MANUAL] ##1 ctrl_reg[BIT_MANUAL];
			endsequence

			AST_MANUAL_XFER: assert property ( // RQ4
				@(posedge i_clock) disable iff (!i_rstn)
				s_manual_rise |-> xfer ##1 (g_cnt[CNT_LCV].u_cnt.count_reg == '0))
				else $error("manual trigger edge did not transfer");
			AST_AUTO_XFER: assert property ( // RQ3
				@(posedge i_clock) disable iff (!i_rstn)
				(ctrl_reg[BIT_AUTO] && tick) |-> xfer)
				else $error("one-second transfer missed");
			AST_NO_IDLE_XFER: assert property ( // RQ3
				@(posedge i_clock) disable iff (!i_rstn)
				(!tick && !manual_rise) |-> !xfer)
				else $error("transfer without cause");
			AST_CRC_ESF_ONLY: assert property ( // RQ11
				@(posedge i_clock) disable iff (!i_rstn)
				(fmt != FMT_ESF) |-> !evt[CNT_CRC])
				else $error("crc6 counted outside extended superframe");
			AST_DDS_T1_ONLY: assert property ( // RQ12
				@(posedge i_clock) disable iff (!i_rstn)
				evt[CNT_DDS] |-> ((fmt == FMT_DM) && !j1_mode && i_dds_error_evt[l]))
				else $error("dds counted outside T1 digital multiplex");
			AST_FLAG_STICKY: assert property ( // RQ17
				@(posedge i_clock) disable iff (!i_rstn)
				(flg0_reg[FLG0_ALIGNMENT_CHANGE_COUNTER] && !clr0[FLG0_ALIGNMENT_CHANGE_COUNTER]) |=> flg0_reg[FLG0_ALIGNMENT_CHANGE_COUNTER])
				else $error("overflow flag dropped without clear");
			AST_FLAG_SET: assert property ( // RQ2
				@(posedge i_clock) disable iff (!i_rstn)
				ovf[CNT_ALIGNMENT_CHANGE_COUNTER] |=> flg0_reg[FLG0_ALIGNMENT_CHANGE_COUNTER] && (link_irq[l] || !en0_reg[FLG0_ALIGNMENT_CHANGE_COUNTER]))
				else $error("alignment change overflow flag not set");
		end
	endgenerate

	// read data appear the cycle after the strobe and only then
	always_comb begin
		rd_next = 8'h00;
		if (i_addr == ADDR_ACCESS_PORT) begin
			rd_next = 8'(access_reg);
		end else if (i_addr == ADDR_ACCESS_DATA) begin
			rd_next = acc_link_ok ? link_ind[acc_link] : 8'h00; // RQ8
		end else if (bus_link_ok) begin
			rd_next = link_rd[bus_link];
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= i_rd ? rd_next : 8'h00; // RQ8
		end
	end

	assign o_rdata = rdata_reg;
	assign o_irq   = |link_irq; // RQ2

	AST_READ_DATA: assert property ( // RQ8
		@(posedge i_clock) disable iff (!i_rstn)
		(i_rd && i_addr == ADDR_ACCESS_DATA && acc_link_ok) |=> o_rdata == $past(link_ind[acc_link]))
		else $error("access data does not show selected indirect byte");
	AST_TICK_PERIOD: assert property ( // RQ3
		@(posedge i_clock) disable iff (!i_rstn)
		tick |=> (tick_cnt_reg == '0))
		else $error("second counter did not restart");
	AST_IRQ_LEVEL: assert property ( // RQ17
		@(posedge i_clock) disable iff (!i_rstn)
		o_irq == |link_irq)
		else $error("interrupt level mismatch");
endmodule // tpm_perf_monitor

/* File: core/tpm_pkg.sv */
// shared constants and types of the T1 performance monitor
package tpm_pkg;
	// clock rate and the one-second transfer interval
	localparam int unsigned CLOCK_HZ         = 100_000_000;
	localparam int unsigned ONE_SECOND_S     = 1;
	localparam int unsigned TICK_CYCLES_DFLT = ONE_SECOND_S * CLOCK_HZ;

	// software port geometry
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;

	// global registers (byte addresses)
	localparam logic [10:0] ADDR_ACCESS_PORT = 11'h00E;
	localparam logic [10:0] ADDR_ACCESS_DATA = 11'h00F;

	// per-link registers: address = {link, offset}
	localparam logic [7:0] OFF_CONTROL  = 8'hC2;
	localparam logic [7:0] OFF_IRQ_EN0  = 8'hC3;
	localparam logic [7:0] OFF_IRQ_EN1  = 8'hC4;
	localparam logic [7:0] OFF_IRQ_FLG0 = 8'hC5;
	localparam logic [7:0] OFF_IRQ_FLG1 = 8'hC6;
	localparam logic [7:0] OFF_IRQ_CLR0 = 8'hC7;
	localparam logic [7:0] OFF_IRQ_CLR1 = 8'hC8;

	// control register fields
	localparam int BIT_MANUAL = 0;
	localparam int BIT_AUTO   = 1;
	localparam int BIT_FMT_LO = 2;
	localparam int BIT_FMT_HI = 3;
	localparam int BIT_J1     = 4;
	localparam int CTRL_W     = 5;

	// access port fields
	localparam int ACC_IDX_LO  = 0;
	localparam int ACC_IDX_HI  = 3;
	localparam int ACC_LINK_LO = 4;
	localparam int ACC_LINK_HI = 6;
	localparam int ACC_W       = 7;

	// values after reset
	localparam logic [CTRL_W-1:0] RST_CONTROL = 5'h00;
	localparam logic [ACC_W-1:0]  RST_ACCESS  = 7'h00;
	localparam logic [7:0]        RST_IRQ     = 8'h00;

	typedef enum logic [1:0] {
		FMT_SF  = 2'h0,
		FMT_ESF = 2'h1,
		FMT_DM  = 2'h2,
		FMT_SLC = 2'h3
	} tpm_format_type;

	// counter set, index and width
	localparam int CNT_LCV  = 0;
	localparam int CNT_FER  = 1;
	localparam int CNT_CRC  = 2;
	localparam int CNT_DDS  = 3;
	localparam int CNT_ALIGNMENT_CHANGE_COUNTER = 4;
	localparam int CNT_OOF  = 5;
	localparam int CNT_PRBS = 6;
	localparam int CNT_NUM  = 7;
	localparam int CNT_WIDTH [CNT_NUM] = '{16, 12, 10, 10, 3, 5, 16};
	localparam int RESULT_W = 16;

	// overflow flag positions: flag register 1 holds only the line counter
	localparam int FLG0_FER  = 0;
	localparam int FLG0_ALIGNMENT_CHANGE_COUNTER = 1;
	localparam int FLG0_OOF  = 2;
	localparam int FLG0_PRBS = 3;
	localparam int FLG0_CRC  = 4;
	localparam int FLG0_DDS  = 5;
	localparam int FLG1_LCV  = 0;

	// indirect result indices
	localparam logic [3:0] IDX_CRC_LO  = 4'h0;
	localparam logic [3:0] IDX_CRC_HI  = 4'h1;
	localparam logic [3:0] IDX_FER_LO  = 4'h2;
	localparam logic [3:0] IDX_FER_HI  = 4'h3;
	localparam logic [3:0] IDX_ALIGNMENT_CHANGE_COUNTER    = 4'h4;
	localparam logic [3:0] IDX_OOF     = 4'h5;
	localparam logic [3:0] IDX_PRBS_LO = 4'h6;
	localparam logic [3:0] IDX_PRBS_HI = 4'h7;
	localparam logic [3:0] IDX_LCV_LO  = 4'h8;
	localparam logic [3:0] IDX_LCV_HI  = 4'h9;
	localparam logic [3:0] IDX_DDS_LO  = 4'hA;
	localparam logic [3:0] IDX_DDS_HI  = 4'hB;
endpackage

/* File: core/tpm_cnt_if.sv */
// link between the monitor control logic and one event counter
`timescale 1ns/10ps
interface tpm_cnt_if;
	logic                          evt;
	logic                          xfer;
	logic [tpm_pkg::RESULT_W-1:0]  result;
	logic                          ovf;
	modport ctl (output evt, output xfer, input result, input ovf);
	modport cnt (input evt, input xfer, output result, output ovf);
endinterface

/* File: core/tpm_counter.sv */
// saturating event counter with transfer-and-clear
`timescale 1ns/10ps
module tpm_counter #(
	parameter int W = 16
) (
	input  wire logic i_clock,
	input  wire logic i_rstn,
	tpm_cnt_if.cnt    cnt
);
	import tpm_pkg::*;

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic [W-1:0] result_reg;
	logic [W-1:0] result_next;
	logic [W-1:0] bumped;
	logic         ovf_reg;
	logic         at_max;

	assign at_max      = &count_reg;
	// an event in the transfer cycle lands in the transferred value
	assign bumped      = count_reg + W'(cnt.evt & ~at_max); // RQ6
	assign count_next  = cnt.xfer ? '0 : bumped; // RQ5
	assign result_next = cnt.xfer ? bumped : result_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			count_reg  <= '0;
			result_reg <= '0;
			ovf_reg    <= 1'b0;
		end else begin
			count_reg  <= count_next;
			result_reg <= result_next;
			ovf_reg    <= cnt.evt & at_max; // RQ2
		end
	end

	assign cnt.result = RESULT_W'(result_reg);
	assign cnt.ovf    = ovf_reg;

	AST_CNT_CLEAR: assert property ( // RQ5
		@(posedge i_clock) disable iff (!i_rstn)
		cnt.xfer |=> (count_reg == '0) && (result_reg == $past(bumped)))
		else $error("counter not cleared after transfer");
	AST_CNT_KEEP: assert property ( // RQ6
		@(posedge i_clock) disable iff (!i_rstn)
		(cnt.xfer && cnt.evt && !at_max) |=> result_reg == $past(count_reg) + W'(1))
		else $error("event lost during transfer");
	AST_CNT_OVF: assert property ( // RQ2
		@(posedge i_clock) disable iff (!i_rstn)
		(cnt.evt && at_max && !cnt.xfer) |=> (ovf_reg && (&count_reg)))
		else $error("overflow not reported or counter wrapped");
endmodule // tpm_counter

/* File: tb/tpm_evt_src.sv */
// event source model standing in for the framer, line decoder and pattern detector
`timescale 1ns/10ps
module tpm_evt_src (
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	input  wire logic       i_go,
	input  wire logic [2:0] i_kind,
	input  wire logic [2:0] i_link,
	input  wire logic [7:0] i_num,
	input  wire logic       i_slow,
	output logic            o_busy,
	output logic [7:0][7:0] o_evt
);
	logic [7:0] left_reg;
	logic [2:0] kind_reg;
	logic [2:0] link_reg;
	logic       slow_reg;
	logic       phase_reg;
	wire        fire = (left_reg != 8'h00) && (!slow_reg || phase_reg);

	// slow mode spaces pulses one idle cycle apart, as a sparse error stream would
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			left_reg <= 8'h00;
			kind_reg <= 3'h0;
			link_reg <= 3'h0;
			slow_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else if (i_go) begin
			left_reg <= i_num;
			kind_reg <= i_kind;
			link_reg <= i_link;
			slow_reg <= i_slow;
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= !phase_reg;
			if (fire) begin
				left_reg <= left_reg - 8'h01;
			end
		end
	end

	always_comb begin
		o_evt = '0;
		o_evt[kind_reg][link_reg] = fire;
	end
	assign o_busy = left_reg != 8'h00;
endmodule // tpm_evt_src

/* File: tb/tpm_perf_monitor_tb_top.sv */
// self-checking testbench of the performance monitor
`timescale 1ns/10ps
module tpm_perf_monitor_tb_top;
	import tpm_pkg::*;
	localparam int TICK = 200;
	logic             clock = 1'b0;
	logic             rstn = 1'b0;
	logic [10:0]      addr = 11'h000;
	logic [7:0]       wdata = 8'h00;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic [7:0]       rdata;
	logic             irq;
	logic             go = 1'b0;
	logic [2:0]       kind = 3'h0;
	logic [2:0]       link = 3'h0;
	logic [7:0]       num = 8'h00;
	logic             slow = 1'b0;
	logic             busy;
	logic [7:0][7:0]  evt;
	int               cyc = 0;
	int               fail_count = 0;
	int               num_checks = 0;
	logic [7:0]       d;
	logic [7:0]       ctl;
	logic [15:0]      va;
	logic [15:0]      vb;

	always #5 clock = ~clock;
	always @(posedge clock) if (rstn) cyc <= cyc + 1;

	tpm_perf_monitor #(.NUM_LINKS(8), .TICK_CYCLES(TICK)) i_dut (
		.i_clock(clock), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_line_violation_evt(evt[0]), .i_fbit_error_evt(evt[1]),
		.i_fas_error_evt(evt[2]), .i_crc6_error_evt(evt[3]), .i_dds_error_evt(evt[4]),
		.i_alignment_change_evt(evt[5]), .i_sync_loss_evt(evt[6]), .i_prbs_error_evt(evt[7]),
		.o_irq(irq));

	tpm_evt_src i_src (
		.i_clock(clock), .i_rstn(rstn), .i_go(go), .i_kind(kind), .i_link(link), .i_num(num),
		.i_slow(slow), .o_busy(busy), .o_evt(evt));

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus_wr(input logic [10:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic bus_rd(input logic [10:0] a, output logic [7:0] v);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic get16(input logic [2:0] l, input logic [3:0] idx, input logic wide, output logic [15:0] v);
		logic [7:0] b;
		v = 16'h0000;
		bus_wr(ADDR_ACCESS_PORT, {1'b0, l, idx});
		bus_rd(ADDR_ACCESS_DATA, b);
		v[7:0] = b;
		if (wide) begin
			bus_wr(ADDR_ACCESS_PORT, {1'b0, l, idx + 4'h1});
			bus_rd(ADDR_ACCESS_DATA, b);
			v[15:8] = b;
		end
	endtask

	task automatic chk_res(input logic [2:0] l, input logic [3:0] idx, input logic wide, input logic [15:0] exp);
		logic [15:0] v;
		get16(l, idx, wide, v);
		chk($sformatf("result link %0d index %h", l, idx), exp, v);
	endtask

	// manual bit is dropped again so that the next call makes a fresh rising edge
	task automatic trigger(input logic [2:0] l, input logic [7:0] c);
		bus_wr({l, OFF_CONTROL}, c | 8'h01);
		bus_wr({l, OFF_CONTROL}, c);
	endtask

	task automatic send(input logic [2:0] k, input logic [2:0] l, input logic [7:0] n, input logic s);
		@(posedge clock);
		go <= 1'b1;
		kind <= k;
		link <= l;
		num <= n;
		slow <= s;
		@(posedge clock);
		go <= 1'b0;
		#1;
		for (int i = 0; i < 300 && busy; i++) begin
			@(posedge clock);
			#1;
		end
	endtask

	initial begin
		repeat (30000) @(posedge clock);
		fail_count++;
		$display("FAIL watchdog expired");
		close_out();
	end

	initial begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		bus_rd({3'h0, OFF_CONTROL}, d);
		chk("control after reset", 16'h0000, {8'h00, d});
		bus_rd({3'h0, 8'hD0}, d);
		chk("unmapped read", 16'h0000, {8'h00, d});
		bus_wr(ADDR_ACCESS_PORT, 8'h7C);
		bus_rd(ADDR_ACCESS_PORT, d);
		chk("access port", 16'h007C, {8'h00, d});
		chk_res(3'h7, 4'hC, 1'b0, 16'h0000);
		$display("test reset and map done");

		// every format, plus digital multiplex in J1 mode
		for (int j = 0; j < 5; j++) begin
			ctl = (j < 4) ? 8'(j << 2) : 8'h18;
			bus_wr({3'h2, OFF_CONTROL}, ctl);
			for (int k = 0; k < 8; k++) send(3'(k), 3'h2, 8'(k + 1), k[0]);
			trigger(3'h2, ctl);
			chk_res(3'h2, IDX_LCV_LO, 1'b1, 16'h0001);
			chk_res(3'h2, IDX_FER_LO, 1'b1, (j == 1) ? 16'h0003 : 16'h0002);
			chk_res(3'h2, IDX_CRC_LO, 1'b1, (j == 1) ? 16'h0004 : 16'h0000);
			chk_res(3'h2, IDX_DDS_LO, 1'b1, (j == 2) ? 16'h0005 : 16'h0000);
			chk_res(3'h2, IDX_ALIGNMENT_CHANGE_COUNTER, 1'b0, 16'h0006);
			chk_res(3'h2, IDX_OOF, 1'b0, (j == 4) ? 16'h0000 : 16'h0007);
			chk_res(3'h2, IDX_PRBS_LO, 1'b1, 16'h0008);
			chk_res(3'h3, IDX_LCV_LO, 1'b1, 16'h0000);
			trigger(3'h2, ctl);
			chk_res(3'h2, IDX_PRBS_LO, 1'b1, 16'h0000);
		end
		$display("test formats done");

		// a transfer in the middle of an event stream loses nothing
		fork
			send(3'h0, 3'h2, 8'd20, 1'b1);
			begin
				repeat (15) @(posedge clock);
				trigger(3'h2, 8'h00);
				get16(3'h2, IDX_LCV_LO, 1'b1, va);
			end
		join
		trigger(3'h2, 8'h00);
		get16(3'h2, IDX_LCV_LO, 1'b1, vb);
		chk("split line count", 16'd20, va + vb);
		$display("test transfer during events done");

		// tick phase is fixed after reset, so the burst lands well inside one interval
		bus_wr({3'h1, OFF_CONTROL}, 8'h02);
		while (cyc % TICK != 10) @(posedge clock);
		send(3'h7, 3'h1, 8'h05, 1'b0);
		while (cyc % TICK != 110) @(posedge clock);
		// the burst is only reported by the tick that closes its interval
		chk_res(3'h1, IDX_PRBS_LO, 1'b1, 16'h0000);
		repeat (TICK) @(posedge clock);
		chk_res(3'h1, IDX_PRBS_LO, 1'b1, 16'h0005);
		repeat (TICK) @(posedge clock);
		chk_res(3'h1, IDX_PRBS_LO, 1'b1, 16'h0000);
		$display("test auto transfer done");

		send(3'h5, 3'h5, 8'h08, 1'b0);
		repeat (3) @(posedge clock);
		bus_rd({3'h5, OFF_IRQ_FLG0}, d);
		chk("overflow flags", 16'h0002, {8'h00, d});
		chk("masked interrupt", 16'h0000, {15'h0000, irq});
		bus_wr({3'h5, OFF_IRQ_EN0}, 8'h02);
		repeat (20) @(posedge clock);
		#1;
		chk("enabled interrupt", 16'h0001, {15'h0000, irq});
		bus_wr({3'h5, OFF_IRQ_CLR0}, 8'h02);
		bus_rd({3'h5, OFF_IRQ_FLG0}, d);
		chk("cleared flags", 16'h0000, {8'h00, d});
		chk("cleared interrupt", 16'h0000, {15'h0000, irq});
		trigger(3'h5, 8'h00);
		chk_res(3'h5, IDX_ALIGNMENT_CHANGE_COUNTER, 1'b0, 16'h0007);
		$display("test overflow done");
		close_out();
	end
endmodule // tpm_perf_monitor_tb_top
